// ---- core/patb_phase_walk.sv ----
// walks the loaded phase table and names the port served next
// assumes advance_i and load_i come from logic on the same clock
`timescale 1ns/1ps
module patb_phase_walk
(
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // table and control
  input  wire logic [31:0]                    table_i,
  input  wire logic [3:0]                     own_port_i,
  input  wire logic                           enable_i,
  input  wire logic                           load_i,
  input  wire logic                           advance_i,
  // current grant
  output logic [3:0]                          served_port_o,
  output logic [patb_pkg::PHASE_IDX_W-1:0]    phase_o,
  output logic                                served_valid_o
);

  logic [patb_pkg::PHASE_COUNT-1:0] valid_vec;
  logic [patb_pkg::PHASE_IDX_W-1:0] next_phase;
  logic                             next_found;
  logic [patb_pkg::PHASE_IDX_W-1:0] start;

  // per-phase validity of the port id
  genvar g;
  generate
    for (g = 0; g < patb_pkg::PHASE_COUNT; g++)
    begin : g_valid
      assign valid_vec[g] = patb_pkg::port_id_valid(
        table_i[g*patb_pkg::PHASE_W +: patb_pkg::PHASE_W], own_port_i);
    end
  endgenerate

  // search starts at phase 0 after a load, else after the current one
  assign start = load_i ? '0 : phase_o + 3'h1;

  // skip invalid entries within the same cycle, no wasted period
  always_comb
  begin
    logic [patb_pkg::PHASE_IDX_W-1:0] idx;
    idx        = '0;
    next_phase = phase_o;
    next_found = 1'b0;
    for (int i = 0; i < patb_pkg::PHASE_COUNT; i++)
    begin
      idx = start + i[patb_pkg::PHASE_IDX_W-1:0];
      if (!next_found && valid_vec[idx])
      begin
        next_phase = idx;
        next_found = 1'b1;
      end
    end
  end

  // grant register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_o        <= '0;
      served_port_o  <= patb_pkg::PORT_UPSTREAM;
      served_valid_o <= 1'b0;
    end
    else if (!enable_i)
      served_valid_o <= 1'b0;
    else if (load_i || advance_i)
    begin
      phase_o        <= next_phase;
      served_port_o  <= table_i[next_phase*patb_pkg::PHASE_W +: patb_pkg::PHASE_W];
      served_valid_o <= next_found;
    end
  end

endmodule : patb_phase_walk

// ---- core/patb_pkg.sv ----
// constants, register map and shared helpers for the port arbitration
// table and channel status block; assumes a 32-bit classic wishbone slave
package patb_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam int          ADR_W        = 12;
  localparam logic [11:0] OFF_CONTROL  = 12'h214;
  localparam logic [11:0] OFF_STATUS   = 12'h218;
  localparam logic [11:0] OFF_TABLE0   = 12'h220;
  localparam logic [11:0] OFF_ARB_CFG  = 12'h230;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h240;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h244;

  // ==========================================================
  // field positions and reset values
  localparam int          CTL_LOAD_BIT     = 16;
  localparam int          STS_COHERENT_BIT = 16;
  localparam int          STS_FC_BIT       = 17;
  localparam int          CFG_USED_BIT     = 0;
  localparam int          SEL_LOAD_LANE    = 2;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

  // ==========================================================
  // phase table layout and port encodings
  localparam int          PHASE_W         = 4;
  localparam int          PHASE_COUNT     = 8;
  localparam int          PHASE_IDX_W     = 3;
  localparam logic [3:0]  PORT_UPSTREAM   = 4'h0;
  localparam logic [3:0]  PORT_FIRST_DOWN = 4'h2;
  localparam logic [3:0]  PORT_LAST_DOWN  = 4'h5;

  // ==========================================================
  // interrupt status bits
  localparam int IRQ_W             = 3;
  localparam int IRQ_LOAD_DONE     = 0;
  localparam int IRQ_FC_DONE       = 1;
  localparam int IRQ_TABLE_WRITTEN = 2;

  // table load handshake towards the arbiter
  typedef enum logic {LOAD_IDLE, LOAD_WAIT} patb_load_type;

  // reserved ids and the egress port itself are not servable
  function automatic logic port_id_valid(input logic [3:0] id, input logic [3:0] own);
    port_id_valid = ((id == PORT_UPSTREAM) ||
                     ((id >= PORT_FIRST_DOWN) && (id <= PORT_LAST_DOWN))) && (id != own);
  endfunction : port_id_valid

endpackage : patb_pkg

// ---- core/patb_top.sv ----
// port arbitration table entry 0, channel status and control registers,
// load handshake with the port arbiter and a walked phase grant
// assumes one 125 MHz clock, classic wishbone master, arbiter on same clock
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module patb_top
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // port straps, from pins
  input  wire logic        port_is_upstream_i,
  input  wire logic [3:0]  own_port_id_i,
  // link and arbiter, same clock
  input  wire logic        fc_init_pending_i,
  input  wire logic        load_done_i,
  input  wire logic        phase_advance_i,
  output logic             table_load_request_o,
  output logic      [31:0] arb_table_o,
  output logic      [3:0]  served_port_o,
  output logic      [2:0]  served_phase_o,
  output logic             served_valid_o,
  // interrupt
  output logic             irq_o
);

  // ==========================================================
  // strap synchronisers
  logic       up_meta;
  logic       up_sync;
  logic [3:0] own_meta;
  logic [3:0] own_sync;

  // straps may move with board state, so resample every cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      up_meta  <= 1'b0;
      up_sync  <= 1'b0;
      own_meta <= 4'h0;
      own_sync <= 4'h0;
    end
    else
    begin
      up_meta  <= port_is_upstream_i;
      up_sync  <= up_meta;
      own_meta <= own_port_id_i;
      own_sync <= own_meta;
    end
  end

  // ==========================================================
  // bus decode
  logic bus_wr;
  logic bus_rd;

  patb_wb_slave u_wb
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .wr_o  (bus_wr),
    .rd_o  (bus_rd),
    .ack_o (ack_o)
  );

  logic hit_ctl;
  logic hit_sts;
  logic hit_tbl;
  logic hit_cfg;
  logic hit_istat;
  logic hit_imask;

  // word decode, low two address bits ignored
  assign hit_ctl   = adr_i[11:2] == patb_pkg::OFF_CONTROL[11:2];
  assign hit_sts   = adr_i[11:2] == patb_pkg::OFF_STATUS[11:2];
  assign hit_tbl   = adr_i[11:2] == patb_pkg::OFF_TABLE0[11:2];
  assign hit_cfg   = adr_i[11:2] == patb_pkg::OFF_ARB_CFG[11:2];
  assign hit_istat = adr_i[11:2] == patb_pkg::OFF_IRQ_STAT[11:2];
  assign hit_imask = adr_i[11:2] == patb_pkg::OFF_IRQ_MASK[11:2];

  // ==========================================================
  // phase table, entry 0
  logic [31:0] next_table;
  logic        table_write;

  // byte-lane merge of a table write
  always_comb
  begin
    next_table = arb_table_o;
    for (int b = 0; b < 4; b++)
    begin
      if (sel_i[b])
        next_table[b*8 +: 8] = dat_i[b*8 +: 8];
    end
  end

  assign table_write = bus_wr && hit_tbl && (sel_i != 4'h0);

  // eight 4-bit phase fields, all read-write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      arb_table_o <= patb_pkg::RESET_WORD;
    else if (table_write)
      arb_table_o <= next_table;
  end

  // ==========================================================
  // arbitration configuration
  logic table_used;

  // selects whether the current scheme walks the table at all
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      table_used <= 1'b0;
    else if (bus_wr && hit_cfg && sel_i[0])
      table_used <= dat_i[patb_pkg::CFG_USED_BIT];
  end

  // ==========================================================
  // table load handshake
  patb_pkg::patb_load_type load_state;
  logic                    load_cmd;
  logic                    load_finish;

  // a zero in the bit does nothing; only upstream ports act on it
  assign load_cmd = bus_wr && hit_ctl && sel_i[patb_pkg::SEL_LOAD_LANE] &&
                    dat_i[patb_pkg::CTL_LOAD_BIT] && up_sync;
  assign load_finish = (load_state == patb_pkg::LOAD_WAIT) && load_done_i;

  // request stays high until the arbiter has latched the table
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      load_state           <= patb_pkg::LOAD_IDLE;
      table_load_request_o <= 1'b0;
    end
    else
    begin
      case (load_state)
        patb_pkg::LOAD_IDLE:
        begin
          if (load_cmd)
          begin
            load_state           <= patb_pkg::LOAD_WAIT;
            table_load_request_o <= 1'b1;
          end
        end
        patb_pkg::LOAD_WAIT:
        begin
          if (load_done_i)
          begin
            load_state           <= patb_pkg::LOAD_IDLE;
            table_load_request_o <= 1'b0;
          end
        end
        default:
        begin
          load_state           <= patb_pkg::LOAD_IDLE;
          table_load_request_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // arbiter's latched copy of the table
  logic [31:0] loaded_table;
  logic        load_seen;

  // the walk keeps the old table until a load completes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loaded_table <= patb_pkg::RESET_WORD;
      load_seen    <= 1'b0;
    end
    else
    begin
      load_seen <= load_finish;
      if (load_finish)
        loaded_table <= arb_table_o;
    end
  end

  patb_phase_walk u_walk
  (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .table_i        (loaded_table),
    .own_port_i     (own_sync),
    .enable_i       (table_used),
    .load_i         (load_seen),
    .advance_i      (phase_advance_i),
    .served_port_o  (served_port_o),
    .phase_o        (served_phase_o),
    .served_valid_o (served_valid_o)
  );

  // ==========================================================
  // channel status
  logic coherency_flag;
  logic fc_pending;

  // a table write in the finishing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      coherency_flag <= 1'b0;
    else if (table_write)
      coherency_flag <= 1'b1;
    else if (load_finish)
      coherency_flag <= 1'b0;
  end

  // registered copy of the flow control init level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fc_pending <= 1'b0;
    else
      fc_pending <= fc_init_pending_i;
  end

  logic [31:0] status_word;

  // reserved bits tie to zero; downstream hides the flag
  always_comb
  begin
    status_word = patb_pkg::RESET_WORD;
    status_word[patb_pkg::STS_COHERENT_BIT] = coherency_flag && up_sync;
    status_word[patb_pkg::STS_FC_BIT]       = fc_pending;
  end

  // ==========================================================
  // interrupt status and mask
  logic [patb_pkg::IRQ_W-1:0] irq_status;
  logic [patb_pkg::IRQ_W-1:0] irq_mask;
  logic [patb_pkg::IRQ_W-1:0] irq_events;
  logic [patb_pkg::IRQ_W-1:0] next_irq_status;

  // end of flow control init seen as a falling pending level
  always_comb
  begin
    irq_events = '0;
    irq_events[patb_pkg::IRQ_LOAD_DONE]     = load_finish;
    irq_events[patb_pkg::IRQ_FC_DONE]       = fc_pending && !fc_init_pending_i;
    irq_events[patb_pkg::IRQ_TABLE_WRITTEN] = table_write;
  end

  // read clears, but an event in that cycle survives
  always_comb
  begin
    next_irq_status = irq_status;
    if (bus_rd && hit_istat)
      next_irq_status = '0;
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= '0;
    else if (bus_wr && hit_imask && sel_i[0])
      irq_mask <= dat_i[patb_pkg::IRQ_W-1:0];
  end

  // level output, from the next status value and the current mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(next_irq_status & irq_mask);
  end

  // ==========================================================
  // read data
  logic [31:0] next_rdata;

  // control reads all zero, so the load bit never shows as set
  always_comb
  begin
    next_rdata = patb_pkg::RESET_WORD;
    if (hit_ctl)
      next_rdata = patb_pkg::RESET_WORD;
    else if (hit_sts)
      next_rdata = status_word;
    else if (hit_tbl)
      next_rdata = arb_table_o;
    else if (hit_cfg)
      next_rdata[patb_pkg::CFG_USED_BIT] = table_used;
    else if (hit_istat)
      next_rdata[patb_pkg::IRQ_W-1:0] = irq_status;
    else if (hit_imask)
      next_rdata[patb_pkg::IRQ_W-1:0] = irq_mask;
  end

  // unmapped reads answer zero rather than an error
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= patb_pkg::RESET_WORD;
    else if (bus_rd)
      dat_o <= next_rdata;
  end

endmodule : patb_top

// ---- core/patb_wb_slave.sv ----
// classic wishbone handshake for the register bank
// assumes a master holding the request until ack; one access per request
`timescale 1ns/1ps
module patb_wb_slave
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bus request
  input  wire logic cyc_i,
  input  wire logic stb_i,
  input  wire logic we_i,
  // access strobes and answer
  output logic      wr_o,
  output logic      rd_o,
  output logic      ack_o
);

  logic acc;

  // one access per request; ack high blocks a second take
  assign acc  = cyc_i && stb_i && !ack_o;
  assign wr_o = acc && we_i;
  assign rd_o = acc && !we_i;

  // registered ack, dropped the cycle after it was given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= acc;
  end

endmodule : patb_wb_slave

// ---- test/patb_arbiter_model.sv ----
// port arbiter stand-in: completes table loads and paces the phase walk
// assumes the request is a level that falls at the edge load done is seen
`timescale 1ns/1ps
module patb_arbiter_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bench controls
  input  wire logic [7:0] delay_i,
  input  wire logic       walk_i,
  // towards the block
  input  wire logic       load_request_i,
  output logic            load_done_o,
  output logic            advance_o
);
  logic [7:0] wait_cnt;
  // ==========================================
  // load completion delay_i + 1 cycles after request, one-cycle pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !load_request_i)
    begin
      wait_cnt    <= 8'h00;
      load_done_o <= 1'b0;
    end
    else
    begin
      wait_cnt    <= wait_cnt + 8'h01;
      load_done_o <= (wait_cnt == delay_i);
    end
  end
  // advance every other cycle so each grant is seen before it moves
  always_ff @(posedge clk_i)
  begin
    advance_o <= !rst_i && walk_i && !advance_o;
  end
endmodule : patb_arbiter_model

// ---- test/patb_monitor.sv ----
// assertion checker for the arbitration table and channel status block
// sees only the top module ports; bound to every patb_top instance
`timescale 1ns/1ps
module patb_monitor
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // straps and arbiter side
  input wire logic        port_is_upstream_i,
  input wire logic [3:0]  own_port_id_i,
  input wire logic        fc_init_pending_i,
  input wire logic        load_done_i,
  input wire logic        table_load_request_o,
  input wire logic [31:0] arb_table_o,
  input wire logic [3:0]  served_port_o,
  input wire logic        served_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // bus steps
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd_status;
    s_take ##0 (!we_i && adr_i == patb_pkg::OFF_STATUS);
  endsequence
  sequence s_load_cmd;
    s_take ##0 (we_i && adr_i == patb_pkg::OFF_CONTROL && sel_i[2] && dat_i[16]);
  endsequence
  // ==========================================
  // properties
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (s_take |=> ack_o)
    else $error("request not answered next cycle");
  chk_load_start: assert property (s_load_cmd ##0 (port_is_upstream_i
    && $past(port_is_upstream_i, 2) && !table_load_request_o) |=> table_load_request_o)
    else $error("load command did not raise request");
  chk_load_idle: assert property (!table_load_request_o
    && !(cyc_i && stb_i && we_i && adr_i == patb_pkg::OFF_CONTROL) |=> !table_load_request_o)
    else $error("request rose without a load command");
  chk_load_hold: assert property (table_load_request_o && !load_done_i |=> table_load_request_o)
    else $error("request dropped before load done");
  chk_load_end: assert property (table_load_request_o && load_done_i |=> !table_load_request_o)
    else $error("request stayed after load done");
  chk_table_write: assert property (s_take ##0 (we_i && adr_i == patb_pkg::OFF_TABLE0
    && sel_i == 4'hF) |=> arb_table_o == $past(dat_i))
    else $error("table entry not written");
  chk_status_resv: assert property (s_rd_status |=> dat_o[15:0] == 16'h0000
    && dat_o[31:18] == 14'h0000)
    else $error("reserved status bits not zero");
  chk_fc_mirror: assert property (s_rd_status |=> dat_o[17] == $past(fc_init_pending_i, 2))
    else $error("fc pending bit wrong");
  chk_down_zero: assert property (s_rd_status ##0 (!port_is_upstream_i
    && !$past(port_is_upstream_i, 2)) |=> !dat_o[16])
    else $error("coherency flag set on downstream port");
  chk_ctl_zero: assert property (s_take ##0 (!we_i && adr_i == patb_pkg::OFF_CONTROL)
    |=> !dat_o[16])
    else $error("load bit read back as one");
  chk_walk_valid: assert property (served_valid_o |-> (served_port_o == 4'h0
    || (served_port_o >= 4'h2 && served_port_o <= 4'h5)) && served_port_o != own_port_id_i)
    else $error("invalid port granted");
endmodule : patb_monitor

bind patb_top patb_monitor u_patb_monitor
(
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .port_is_upstream_i(port_is_upstream_i), .own_port_id_i(own_port_id_i),
  .fc_init_pending_i(fc_init_pending_i), .load_done_i(load_done_i),
  .table_load_request_o(table_load_request_o), .arb_table_o(arb_table_o),
  .served_port_o(served_port_o), .served_valid_o(served_valid_o)
);

// ---- test/port_arb_table_status_test.sv ----
// self-checking bench for the arbitration table and channel status block
// assumes the arbiter model on the far side and one 125 MHz clock
`timescale 1ns/1ps
module port_arb_table_status_test;
  localparam logic        WR  = 1'b1;
  localparam logic        RD  = 1'b0;
  localparam logic [31:0] TBL = 32'h1062_5F31;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, up_i, fc_i, done_i, adv_i;
  logic        req_o, valid_o, irq_o, walk;
  logic [11:0] adr_i;
  logic [3:0]  sel_i, port_o, own_i;
  logic [2:0]  phase_o;
  logic [7:0]  delay;
  logic [31:0] dat_i, dat_o, tbl_o, q;
  int          n_mismatch, comparisons;

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  patb_top u_patb_top
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_is_upstream_i(up_i), .own_port_id_i(own_i), .fc_init_pending_i(fc_i),
    .load_done_i(done_i), .phase_advance_i(adv_i), .table_load_request_o(req_o),
    .arb_table_o(tbl_o), .served_port_o(port_o), .served_phase_o(phase_o),
    .served_valid_o(valid_o), .irq_o(irq_o)
  );
  patb_arbiter_model u_patb_arbiter_model
  (
    .clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .walk_i(walk),
    .load_request_i(req_o), .load_done_o(done_i), .advance_o(adv_i)
  );
  // ==========================================
  // shared tasks
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait step; a hang ends the run as a failure
  task automatic step(inout int n);
    n++;
    if (n > 100)
    begin
      n_mismatch++;
      results();
    end
    else
      @(posedge clk_i);
  endtask : step
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      step(n);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wait_idle;
    int n;
    n = 0;
    while (req_o !== 1'b0)
      step(n);
  endtask : wait_idle
  // ==========================================
  // scenarios
  task automatic t_reset;
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, patb_pkg::RESET_WORD);
    wb(RD, patb_pkg::OFF_TABLE0, 32'h0, 4'hF);
    check(q, patb_pkg::RESET_WORD);
    wb(WR, 12'h300, 32'hFFFF_FFFF, 4'hF);
    wb(RD, 12'h300, 32'h0, 4'hF);
    check(q, 32'h0);
  endtask : t_reset
  task automatic t_fc;
    fc_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0002_0000);
    fc_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0);
  endtask : t_fc
  // slow arbiter so the flag can be seen standing mid-load
  task automatic t_load;
    delay <= 8'h14;
    wb(RD, patb_pkg::OFF_IRQ_STAT, 32'h0, 4'hF);
    check(q, 32'h0000_0002);
    wb(WR, patb_pkg::OFF_TABLE0, 32'hFFFF_FFFF, 4'h2);
    check(tbl_o, 32'h0000_FF00);
    wb(WR, patb_pkg::OFF_TABLE0, 32'h5432_0054, 4'hF);
    wb(RD, patb_pkg::OFF_TABLE0, 32'h0, 4'hF);
    check(q, 32'h5432_0054);
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0001_0000);
    wb(WR, patb_pkg::OFF_CONTROL, 32'h0001_0000, 4'h4);
    check({31'h0, req_o}, 32'h1);
    wb(RD, patb_pkg::OFF_CONTROL, 32'h0, 4'hF);
    check({31'h0, q[16]}, 32'h0);
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0001_0000);
    wait_idle();
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wb(WR, patb_pkg::OFF_IRQ_MASK, 32'h1, 4'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h1);
    wb(RD, patb_pkg::OFF_IRQ_STAT, 32'h0, 4'hF);
    check(q, 32'h5);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
  endtask : t_load
  // reserved ids and the own id 5 must be skipped: only phases 1, 4, 6 serve
  task automatic t_walk;
    logic [2:0] prev;
    int         hops;
    prev = 3'h6;
    hops = 0;
    delay <= 8'h00;
    wb(WR, patb_pkg::OFF_ARB_CFG, 32'h1, 4'h1);
    wb(WR, patb_pkg::OFF_TABLE0, TBL, 4'hF);
    wb(WR, patb_pkg::OFF_CONTROL, 32'h0001_0000, 4'h4);
    wait_idle();
    walk <= 1'b1;
    repeat (24)
    begin
      @(posedge clk_i);
      if (valid_o === 1'b1 && phase_o !== prev)
      begin
        check({29'h0, phase_o}, prev == 3'h1 ? 32'h4 : prev == 3'h4 ? 32'h6 : 32'h1);
        check({28'h0, port_o}, {28'h0, TBL[phase_o*4 +: 4]});
        prev = phase_o;
        hops++;
      end
    end
    check({31'h0, hops > 8}, 32'h1);
    walk <= 1'b0;
    wb(WR, patb_pkg::OFF_ARB_CFG, 32'h0, 4'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, valid_o}, 32'h0);
  endtask : t_walk
  task automatic t_down;
    up_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(WR, patb_pkg::OFF_TABLE0, 32'h2, 4'hF);
    wb(RD, patb_pkg::OFF_STATUS, 32'h0, 4'hF);
    check(q, 32'h0);
    wb(WR, patb_pkg::OFF_CONTROL, 32'h0001_0000, 4'h4);
    check({31'h0, req_o}, 32'h0);
  endtask : t_down

  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'h0;
    dat_i = 32'h0;
    up_i  = 1'b1;
    own_i = 4'h5;
    fc_i  = 1'b0;
    walk  = 1'b0;
    delay = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_fc();
    t_load();
    t_walk();
    t_down();
    results();
  end
endmodule : port_arb_table_status_test
